// ---- rtl/fcrp_ctrl.v ----
// Configure, version, relative seek and perpendicular mode command block
//
// Behaviour
// - Implied seek on: seek to target cylinder before read/write; default off.
// - fifo_off set means byte-by-byte requests; resets to 1, threshold one.
// - Polling enabled by default; one interrupt raised after reset.
// - No polling while head loaded and unload delay still running.
// - Threshold code plus one gives 1 to 16 bytes; default one byte.
// - Precompensation start track is 8 bits, default track 0.
// - Version query returns a fixed enhanced-controller byte, no interrupt.
// - Step direction 0 steps outward, 1 steps inward.
// - Relative step issues exactly the count, up to 256 pulses.
// - Outward step past track zero sets equipment check, status bit 4.
// - Present cylinder wraps modulo 256; no extended-area indication.
// - Home seek watches track-zero sense, at most 80 pulses, else error.
// - Both selects 0: flagged drives perpendicular, rate-sized Gap2, no precomp.
// - Unflagged drive is conventional, using programmed precompensation.
// - Per-drive flags change only when overwrite enable is 1.
// - Either select bit 1: flags ignored, selected mode for all drives.
// - Of the configuration and perpendicular settings, software reset clears only the two select bits.
// - Hardware reset clears select bits and all per-drive flags.
// - Codes 10,01, and 00 except a flagged drive at 1M: VCO 33, Gap2 22, written 19 or 0, read 24.
// - Code 11: VCO 18, Gap2 41, written 38, read VCO 43.
// - Per-drive flags readable in the eighth state dump byte.
// - Step command completion raises interrupt until sense clears it.
// - Direction set 1 inward, 0 outward before any step pulse.
`timescale 1ns/1ns
`include "fcrp_map.vh"
module fcrp_ctrl
#(
  parameter STEP_GAP_US  = `FCRP_STEP_GAP_US,
  parameter VERSION_CODE = 8'h5a  // Arbitrary identification value
)
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        home_track_sense,
  input  wire        head_unload_busy,
  input  wire [1:0]  drive_sel,
  input  wire        data_rate_1m,
  input  wire        rw_req,
  input  wire [7:0]  rw_target,
  output reg         rw_go,
  output reg         step_pulse,
  output reg         step_dir,
  output reg         int_req,
  output reg  [4:0]  fifo_req_bytes,
  output reg         precomp_enable,
  output reg         perp_active,
  output reg  [7:0]  vco_low_index,
  output reg  [7:0]  gap2_length,
  output reg  [7:0]  gap2_written,
  output reg  [7:0]  vco_low_read
);
  localparam [19:0] STEP_GAP_CYC = STEP_GAP_US * `FCRP_CLK_MHZ;
  localparam [19:0] STEP_PW_CYC  = `FCRP_STEP_PW_NS * `FCRP_CLK_MHZ / 1000;
  localparam [19:0] POLL_CYC     = `FCRP_POLL_DLY_US * `FCRP_CLK_MHZ;
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_DIR   = 3'd1;
  localparam [2:0] S_PULSE = 3'd2;
  localparam [2:0] S_GAP   = 3'd3;
  localparam [2:0] S_DONE  = 3'd4;
  localparam [1:0] M_REL   = 2'd0;
  localparam [1:0] M_ABS   = 2'd1;
  localparam [1:0] M_HOME  = 2'd2;

  reg        implied_seek_enable_reg;
  reg        fifo_off_reg;
  reg        poll_disable_reg;
  reg [3:0]  fifo_level_threshold_reg;
  reg [7:0]  precomp_start_track_reg;
  reg        long_preamble_select_reg;
  reg        perp_write_timing_select_reg;
  reg [3:0]  drive_perp_flags_reg;
  reg [7:0]  present_cylinder_reg;
  reg [7:0]  status_byte_zero_reg;
  reg [7:0]  result_reg;
  reg [7:0]  target_reg;
  reg [8:0]  remain_reg;
  reg [7:0]  home_cnt_reg;
  reg [19:0] timer_reg;
  reg [2:0]  state_reg;
  reg [1:0]  mode_reg;
  reg        ec_reg;
  reg        poll_done_reg;
  reg [19:0] poll_cnt_reg;
  reg        home_meta_reg;
  reg        home_sync_reg;
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  wire       wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire       rd_fire = s_axi_arvalid && !s_axi_rvalid;
  wire       cmd_wr  = wr_fire && (aw_addr_reg == `FCRP_ADDR_CMD) &&
                       w_strb_reg[2];
  wire       do_rel  = cmd_wr && w_data_reg[`FCRP_CMD_REL];
  wire       do_home = cmd_wr && w_data_reg[`FCRP_CMD_HOME];
  wire       do_sns  = cmd_wr && w_data_reg[`FCRP_CMD_SENSE];
  wire       do_ver  = cmd_wr && w_data_reg[`FCRP_CMD_VER];
  wire       do_srst = cmd_wr && w_data_reg[`FCRP_CMD_SRST];
  wire       idle    = (state_reg == S_IDLE);
  wire       step_in = step_dir;
  wire [1:0] sel_code = {long_preamble_select_reg,
                         perp_write_timing_select_reg};
  wire       done_evt = (state_reg == S_DONE) && (mode_reg != M_ABS);
  wire       poll_evt;
  wire [7:0] dump8 = {2'b00, drive_perp_flags_reg, long_preamble_select_reg,
                      perp_write_timing_select_reg};

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_arready = !s_axi_rvalid;

  // Pin input crosses into the clock domain
  always @(posedge aclk)
  begin
    home_meta_reg <= home_track_sense;
    home_sync_reg <= home_meta_reg;
  end

  // Write channel capture in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FCRP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_reg)
          `FCRP_ADDR_CONFIG, `FCRP_ADDR_PERP, `FCRP_ADDR_CMD:
            s_axi_bresp <= `FCRP_RESP_OKAY;
          `FCRP_ADDR_STATUS, `FCRP_ADDR_GAP, `FCRP_ADDR_DUMP8:
            s_axi_bresp <= `FCRP_RESP_OKAY;
          default:
            s_axi_bresp <= `FCRP_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration and perpendicular settings
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      implied_seek_enable_reg      <= 1'b0;
      fifo_off_reg                 <= 1'b1;
      poll_disable_reg             <= 1'b0;
      fifo_level_threshold_reg     <= `FCRP_THR_RST;
      precomp_start_track_reg      <= `FCRP_TRK_RST;
      long_preamble_select_reg     <= 1'b0;
      perp_write_timing_select_reg <= 1'b0;
      drive_perp_flags_reg         <= 4'h0;
    end
    else if (do_srst)
    begin
      long_preamble_select_reg     <= 1'b0;
      perp_write_timing_select_reg <= 1'b0;
    end
    else if (wr_fire && aw_addr_reg == `FCRP_ADDR_CONFIG)
    begin
      if (w_strb_reg[0])
      begin
        implied_seek_enable_reg  <= w_data_reg[`FCRP_CFG_EIS];
        fifo_off_reg             <= w_data_reg[`FCRP_CFG_FOFF];
        poll_disable_reg         <= w_data_reg[`FCRP_CFG_POLLDIS];
        fifo_level_threshold_reg <= w_data_reg[`FCRP_CFG_THR];
      end
      if (w_strb_reg[1])
        precomp_start_track_reg  <= w_data_reg[`FCRP_CFG_TRK];
    end
    else if (wr_fire && aw_addr_reg == `FCRP_ADDR_PERP && w_strb_reg[0])
    begin
      long_preamble_select_reg     <= w_data_reg[`FCRP_PRP_GAP];
      perp_write_timing_select_reg <= w_data_reg[`FCRP_PRP_WG];
      if (w_data_reg[`FCRP_PRP_OW])
        drive_perp_flags_reg <= w_data_reg[`FCRP_PRP_DRV];
    end
  end

  assign poll_evt = !poll_done_reg && !poll_disable_reg &&
                    !head_unload_busy && (poll_cnt_reg == POLL_CYC);
  always @(posedge aclk)
  begin
    if (!aresetn || do_srst)
    begin
      poll_done_reg <= 1'b0;
      poll_cnt_reg  <= 20'h00000;
    end
    else if (poll_disable_reg)
      poll_done_reg <= 1'b1;
    else if (poll_evt)
      poll_done_reg <= 1'b1;
    else if (poll_cnt_reg != POLL_CYC)
      poll_cnt_reg <= poll_cnt_reg + 20'h00001;
  end

  // Stepper sequencer; a second request while busy is simply ignored,
  // since the host must not overlap relative steps
  always @(posedge aclk)
  begin
    if (!aresetn || do_srst)
    begin
      state_reg            <= S_IDLE;
      mode_reg             <= M_REL;
      step_pulse           <= 1'b0;
      step_dir             <= 1'b0;
      remain_reg           <= 9'h000;
      home_cnt_reg         <= 8'h00;
      timer_reg            <= 20'h00000;
      target_reg           <= 8'h00;
      ec_reg               <= 1'b0;
      rw_go                <= 1'b0;
      present_cylinder_reg <= 8'h00;
    end
    else
    begin
      rw_go <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          ec_reg <= 1'b0;
          if (do_rel)
          begin
            mode_reg <= M_REL;
            step_dir <= w_data_reg[`FCRP_CMD_DIR];
            remain_reg <= (w_data_reg[`FCRP_CMD_CNT] > `FCRP_CNT_MAX) ?
                          `FCRP_CNT_MAX : w_data_reg[`FCRP_CMD_CNT];
            state_reg <= S_DIR;
          end
          else if (do_home)
          begin
            mode_reg     <= M_HOME;
            step_dir     <= 1'b0;
            home_cnt_reg <= 8'h00;
            state_reg    <= S_DIR;
          end
          else if (rw_req)
          begin
            if (implied_seek_enable_reg &&
                rw_target != present_cylinder_reg)
            begin
              mode_reg   <= M_ABS;
              target_reg <= rw_target;
              step_dir   <= (rw_target > present_cylinder_reg);
              state_reg  <= S_DIR;
            end
            else
              rw_go <= 1'b1;
          end
        end
        S_DIR:
        begin
          if ((mode_reg == M_REL && remain_reg == 9'h000) ||
              (mode_reg == M_HOME && home_sync_reg))
            state_reg <= S_DONE;
          else if (mode_reg == M_HOME && home_cnt_reg == `FCRP_HOME_MAX)
          begin
            ec_reg    <= 1'b1;
            state_reg <= S_DONE;
          end
          else
          begin
            step_pulse <= 1'b1;
            timer_reg  <= STEP_PW_CYC;
            state_reg  <= S_PULSE;
            if (mode_reg == M_REL && !step_in &&
                present_cylinder_reg == 8'h00)
              ec_reg <= 1'b1;
            if (step_in)
              present_cylinder_reg <= present_cylinder_reg + 8'h01;
            else
              present_cylinder_reg <= present_cylinder_reg - 8'h01;
            remain_reg   <= remain_reg - 9'h001;
            home_cnt_reg <= home_cnt_reg + 8'h01;
          end
        end
        S_PULSE:
        begin
          if (timer_reg == 20'h00001)
          begin
            step_pulse <= 1'b0;
            timer_reg  <= STEP_GAP_CYC;
            state_reg  <= S_GAP;
          end
          else
            timer_reg <= timer_reg - 20'h00001;
        end
        S_GAP:
        begin
          if (timer_reg == 20'h00001)
          begin
            if (mode_reg == M_ABS && present_cylinder_reg == target_reg)
              state_reg <= S_DONE;
            else
              state_reg <= S_DIR;
          end
          else
            timer_reg <= timer_reg - 20'h00001;
        end
        S_DONE:
        begin
          if (mode_reg == M_HOME && !ec_reg)
            present_cylinder_reg <= 8'h00;
          if (mode_reg == M_ABS)
            rw_go <= 1'b1;
          state_reg <= S_IDLE;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // Interrupt, status byte zero and result byte; a new event beats a sense
  always @(posedge aclk)
  begin
    if (!aresetn || do_srst)
    begin
      int_req              <= 1'b0;
      status_byte_zero_reg <= 8'h00;
      result_reg           <= 8'h00;
    end
    else
    begin
      if (do_sns)
        result_reg <= int_req ? status_byte_zero_reg : `FCRP_ST0_INVALID;
      else if (do_ver)
        result_reg <= VERSION_CODE;
      if (done_evt)
      begin
        int_req <= 1'b1;
        status_byte_zero_reg <= `FCRP_ST0_SE |
                                (ec_reg ? `FCRP_ST0_EC : 8'h00) |
                                ((ec_reg && mode_reg == M_HOME) ?
                                 `FCRP_ST0_ABN : 8'h00);
      end
      else if (poll_evt)
      begin
        int_req              <= 1'b1;
        status_byte_zero_reg <= `FCRP_ST0_POLL;
      end
      else if (do_sns)
        int_req <= 1'b0;
    end
  end

  // Derived per-drive outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fifo_req_bytes <= 5'h01;
      precomp_enable <= 1'b0;
      perp_active    <= 1'b0;
      vco_low_index  <= `FCRP_VCO_IDX_STD;
      gap2_length    <= `FCRP_GAP2_STD;
      gap2_written   <= `FCRP_GAP2W_NONE;
      vco_low_read   <= `FCRP_VCO_RD_STD;
    end
    else
    begin
      fifo_req_bytes <= fifo_off_reg ? 5'h01 :
                        {1'b0, fifo_level_threshold_reg} + 5'h01;
      precomp_enable <= !(sel_code == 2'b00 &&
                          drive_perp_flags_reg[drive_sel]) &&
                        (present_cylinder_reg >= precomp_start_track_reg);
      if (sel_code == 2'b11 ||
          (sel_code == 2'b00 && drive_perp_flags_reg[drive_sel] &&
           data_rate_1m))
      begin
        perp_active   <= 1'b1;
        vco_low_index <= `FCRP_VCO_IDX_1M;
        gap2_length   <= `FCRP_GAP2_1M;
        gap2_written  <= `FCRP_GAP2W_1M;
        vco_low_read  <= `FCRP_VCO_RD_1M;
      end
      else
      begin
        perp_active   <= (sel_code == 2'b01) ||
                         (sel_code == 2'b00 &&
                          drive_perp_flags_reg[drive_sel]);
        vco_low_index <= `FCRP_VCO_IDX_STD;
        gap2_length   <= `FCRP_GAP2_STD;
        gap2_written  <= ((sel_code == 2'b01) ||
                          (sel_code == 2'b00 &&
                           drive_perp_flags_reg[drive_sel])) ?
                         `FCRP_GAP2W_500K : `FCRP_GAP2W_NONE;
        vco_low_read  <= `FCRP_VCO_RD_STD;
      end
    end
  end

  // Register read port
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `FCRP_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `FCRP_RESP_OKAY;
      case (s_axi_araddr)
        `FCRP_ADDR_CONFIG:
          s_axi_rdata <= {16'h0000, precomp_start_track_reg,
                          fifo_level_threshold_reg, 1'b0, poll_disable_reg,
                          fifo_off_reg, implied_seek_enable_reg};
        `FCRP_ADDR_PERP:
          s_axi_rdata <= {26'h0000000, drive_perp_flags_reg,
                          perp_write_timing_select_reg,
                          long_preamble_select_reg};
        `FCRP_ADDR_CMD:
          s_axi_rdata <= 32'h0000_0000;
        `FCRP_ADDR_STATUS:
          s_axi_rdata <= {result_reg, 6'h00, int_req, !idle,
                          status_byte_zero_reg, present_cylinder_reg};
        `FCRP_ADDR_GAP:
          s_axi_rdata <= {vco_low_read, gap2_written, gap2_length,
                          vco_low_index};
        `FCRP_ADDR_DUMP8:
          s_axi_rdata <= {24'h000000, dump8};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `FCRP_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // fcrp_ctrl

// ---- rtl/fcrp_map.vh ----
// Register map, field positions and timing constants of the command block
`ifndef FCRP_MAP_VH
`define FCRP_MAP_VH
// Byte addresses
`define FCRP_ADDR_CONFIG   8'h00
`define FCRP_ADDR_PERP     8'h04
`define FCRP_ADDR_CMD      8'h08
`define FCRP_ADDR_STATUS   8'h0c
`define FCRP_ADDR_GAP      8'h10
`define FCRP_ADDR_DUMP8    8'h14
// Configuration fields and reset values
`define FCRP_CFG_EIS       0
`define FCRP_CFG_FOFF      1
`define FCRP_CFG_POLLDIS   2
`define FCRP_CFG_THR       7:4
`define FCRP_CFG_TRK       15:8
`define FCRP_THR_RST       4'h0
`define FCRP_TRK_RST       8'h00
// Perpendicular fields
`define FCRP_PRP_GAP       0
`define FCRP_PRP_WG        1
`define FCRP_PRP_DRV       5:2
`define FCRP_PRP_OW        7
// Command fields
`define FCRP_CMD_CNT       8:0
`define FCRP_CMD_DIR       12
`define FCRP_CMD_REL       16
`define FCRP_CMD_HOME      17
`define FCRP_CMD_SENSE     18
`define FCRP_CMD_VER       19
`define FCRP_CMD_SRST      20
`define FCRP_CNT_MAX       9'h100
// Status byte zero codes
`define FCRP_ST0_EC        8'h10
`define FCRP_ST0_SE        8'h20
`define FCRP_ST0_ABN       8'h40
`define FCRP_ST0_POLL      8'hc0
`define FCRP_ST0_INVALID   8'h80
// Gap2 and VCO byte counts
`define FCRP_VCO_IDX_STD   8'h21
`define FCRP_GAP2_STD      8'h16
`define FCRP_GAP2W_500K    8'h13
`define FCRP_GAP2W_NONE    8'h00
`define FCRP_VCO_RD_STD    8'h18
`define FCRP_VCO_IDX_1M    8'h12
`define FCRP_GAP2_1M       8'h29
`define FCRP_GAP2W_1M      8'h26
`define FCRP_VCO_RD_1M     8'h2b
// Homing limit
`define FCRP_HOME_MAX      8'h50
// Timing and bus response codes
`define FCRP_CLK_MHZ       100
`define FCRP_STEP_PW_NS    1000
`define FCRP_POLL_DLY_US   10
`define FCRP_STEP_GAP_US   3000
`define FCRP_RESP_OKAY     2'b00
`define FCRP_RESP_SLVERR   2'b10
`endif

// ---- verification/fcrp_drive_model.sv ----
// Behavioural drive head on the step and direction lines
`timescale 1ns/1ns
module fcrp_drive_model (
  input  wire aclk,
  input  wire step_pulse,
  input  wire step_dir,
  output wire home_track_sense
);
  integer pos = 7;
  integer pulses = 0;
  reg     last = 1'b0;
  assign home_track_sense = (pos == 0);
  always @(posedge aclk)
  begin
    last <= step_pulse;
    if (step_pulse && !last)
    begin
      pulses <= pulses + 1;
      if (step_dir)
        pos <= pos + 1;
      else if (pos > 0)
        pos <= pos - 1;
    end
  end
endmodule // fcrp_drive_model

// ---- verification/fcrp_monitor.sv ----
// Checker on the command block ports
`timescale 1ns/1ns
module fcrp_monitor (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire       rw_go,
  input wire       step_pulse,
  input wire       step_dir,
  input wire       int_req,
  input wire [4:0] fifo_req_bytes,
  input wire       perp_active,
  input wire [7:0] vco_low_index,
  input wire [7:0] gap2_length,
  input wire [7:0] gap2_written,
  input wire [7:0] vco_low_read
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_step_width:
    assert property ($rose(step_pulse) |-> ##99 step_pulse ##1 !step_pulse)
    else $error("step pulse width wrong");
  a_dir_steady:
    assert property (step_pulse |-> $stable(step_dir))
    else $error("direction moved during pulse");
  a_fifo_range:
    assert property (fifo_req_bytes inside {[1:16]})
    else $error("fifo request size out of range");
  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_single:
    assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid && s_axi_arready)
    else $error("read answer not closed after handshake");
  a_gap_table:
    assert property (gap2_length == 8'h16 ? (vco_low_index == 8'h21 &&
      vco_low_read == 8'h18 && gap2_written inside {8'h00, 8'h13}) :
      (gap2_length == 8'h29 && vco_low_index == 8'h12 &&
      gap2_written == 8'h26 && vco_low_read == 8'h2b))
    else $error("gap timing set inconsistent");
  a_perp_written:
    assert property (perp_active == (gap2_written != 8'h00))
    else $error("perpendicular flag and gap write differ");
  a_reset_clear:
    assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
      !step_pulse && !int_req && fifo_req_bytes == 5'h01 && !perp_active)
    else $error("outputs not cleared by reset");
  a_int_hold:
    assert property ($fell(int_req) |-> $rose(s_axi_bvalid))
    else $error("interrupt cleared without command");
  a_go_pulse:
    assert property (rw_go |=> !rw_go)
    else $error("transfer start longer than one cycle");
  c_step: cover property ($rose(step_pulse));
  c_go: cover property (rw_go);
  c_int: cover property ($fell(int_req));
endmodule // fcrp_monitor
bind fcrp_ctrl fcrp_monitor mon (.*);

// ---- verification/testbench.sv ----
// Self-checking bench for the command block
`timescale 1ns/1ns
`include "fcrp_map.vh"
module testbench;
  localparam [7:0] VC = 8'h3c;  // Arbitrary identification value
  reg         aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  reg         s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  reg         s_axi_arvalid = 1'b0, head_unload_busy = 1'b0, rw_req = 1'b0;
  reg         data_rate_1m = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rw_target = 8'h02;
  reg  [31:0] s_axi_wdata = 32'h0, rd, cw;
  reg  [3:0]  s_axi_wstrb = 4'hf, thr;
  reg  [1:0]  drive_sel = 2'h0, rs, bs;
  reg  [7:0]  trk;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, home_track_sense, rw_go, step_pulse, step_dir;
  wire        int_req, precomp_enable, perp_active;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [4:0]  fifo_req_bytes;
  wire [7:0]  vco_low_index, gap2_length, gap2_written, vco_low_read;
  integer     n_fail = 0, checks_done = 0, k, p0;
  always #5 aclk = ~aclk;
  fcrp_ctrl #(.STEP_GAP_US(1), .VERSION_CODE(VC)) dut (.*);
  fcrp_drive_model drv (.*);
  function [31:0] gexp(input m1, input [7:0] w);
    gexp = m1 ? {8'h2b, 8'h26, 8'h29, 8'h12} : {8'h18, w, 8'h16, 8'h21};
  endfunction
  task finish_test;
  begin
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task tmo;
  begin
    n_fail = n_fail + 1;
    $display("[ERR] wait exp done got timeout");
    finish_test;
  end
  endtask
  task axw(input [7:0] a, input [31:0] d);
    integer i;
    reg kb;
  begin
    kb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 60 && !kb; i = i + 1)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      kb = s_axi_bvalid;
      bs = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
    if (!kb)
      tmo;
  end
  endtask
  task axr(input [7:0] a);
    integer i;
    reg kr;
  begin
    kr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 60 && !kr; i = i + 1)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      kr = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
    if (!kr)
      tmo;
  end
  endtask
  task wint;
    integer i;
  begin
    for (i = 0; i < 20000 && int_req !== 1'b1; i = i + 1)
      @(posedge aclk);
    if (int_req !== 1'b1)
      tmo;
  end
  endtask
  task sns;
  begin
    axw(`FCRP_ADDR_CMD, 32'h40000);
    axr(`FCRP_ADDR_STATUS);
  end
  endtask
  task hrst;
  begin
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  end
  endtask
  initial
  begin
    k = $urandom(92);
    hrst;
    wint;
    sns;
    chk("poll", 32'hc0, rd[31:24]);
    axr(`FCRP_ADDR_CONFIG);
    chk("cfgrst", 32'h2, rd);
    chk("fifo1", 32'h1, fifo_req_bytes);
    axr(`FCRP_ADDR_GAP);
    chk("gaprst", gexp(0, 0), rd);
    axr(8'h20);
    chk("unmap", 32'h2, rs);
    axw(8'h20, 32'h0);
    chk("wunmap", 32'h2, bs);
    $display("test reset done");
    p0 = drv.pulses;
    axw(`FCRP_ADDR_CMD, 32'h20000);
    wint;
    sns;
    chk("home", 32'h2000, rd[15:0]);
    chk("hpuls", 32'h7, drv.pulses - p0);
    chk("intclr", 32'h0, int_req);
    axw(`FCRP_ADDR_CONFIG, 32'h3);
    p0 = drv.pulses;
    rw_req <= 1'b1;
    @(posedge aclk);
    rw_req <= 1'b0;
    for (k = 0; k < 2000 && rw_go !== 1'b1; k = k + 1)
      @(posedge aclk);
    if (rw_go !== 1'b1)
      tmo;
    axr(`FCRP_ADDR_STATUS);
    chk("iseek", 32'h2, rd[7:0]);
    chk("ipuls", 32'h2, drv.pulses - p0);
    p0 = drv.pulses;
    axw(`FCRP_ADDR_CMD, 32'h10003);
    wint;
    sns;
    chk("relout", 32'h30ff, rd[15:0]);
    chk("rpuls", 32'h3, drv.pulses - p0);
    axw(`FCRP_ADDR_CMD, 32'h11001);
    wint;
    sns;
    chk("relin", 32'h2000, rd[15:0]);
    chk("pos", 32'h1, drv.pos);
    // Head parked beyond the homing reach makes the home seek give up
    axw(`FCRP_ADDR_CMD, 32'h1105a);
    wint;
    sns;
    chk("rel90", 32'h205a, rd[15:0]);
    p0 = drv.pulses;
    axw(`FCRP_ADDR_CMD, 32'h20000);
    wint;
    sns;
    chk("herr", 32'h700a, rd[15:0]);
    chk("hpul80", 32'h50, drv.pulses - p0);
    axw(`FCRP_ADDR_CMD, 32'h80000);
    axr(`FCRP_ADDR_STATUS);
    chk("ver", VC, rd[31:24]);
    chk("noint", 32'h0, int_req);
    $display("test stepping done");
    for (k = 0; k < 4; k = k + 1)
    begin
      thr = (k == 0) ? 4'hf : $urandom;
      trk = (k == 1) ? 8'hff : $urandom;
      cw = {16'h0, trk, thr, 4'h0};
      axw(`FCRP_ADDR_CONFIG, cw);
      axr(`FCRP_ADDR_CONFIG);
      chk("cfg", cw, rd);
      chk("fifo", thr + 32'h1, fifo_req_bytes);
    end
    axw(`FCRP_ADDR_CONFIG, 32'hf2);
    axr(`FCRP_ADDR_GAP);
    chk("fifoff", 32'h1, fifo_req_bytes);
    $display("test config done");
    axw(`FCRP_ADDR_PERP, 32'h84);
    axr(`FCRP_ADDR_GAP);
    chk("g500", gexp(0, 8'h13), rd);
    chk("perp", 32'h2, {perp_active, precomp_enable});
    data_rate_1m <= 1'b1;
    axr(`FCRP_ADDR_GAP);
    chk("g1m", gexp(1, 0), rd);
    drive_sel <= 2'h1;
    axr(`FCRP_ADDR_GAP);
    chk("gconv", gexp(0, 0), rd);
    chk("pconv", 32'h1, precomp_enable);
    axw(`FCRP_ADDR_PERP, 32'h0);
    axr(`FCRP_ADDR_DUMP8);
    chk("keep", 32'h4, rd);
    axw(`FCRP_ADDR_PERP, 32'h3);
    axr(`FCRP_ADDR_GAP);
    chk("gall", gexp(1, 0), rd);
    axw(`FCRP_ADDR_CMD, 32'h100000);
    axr(`FCRP_ADDR_DUMP8);
    chk("srst", 32'h4, rd);
    head_unload_busy <= 1'b1;
    hrst;
    axr(`FCRP_ADDR_DUMP8);
    chk("hrst", 32'h0, rd);
    // Poll delay is fixed, so a fixed wait past it is safe
    repeat (1500) @(posedge aclk);
    chk("nopoll", 32'h0, int_req);
    $display("test perpendicular done");
    finish_test;
  end
endmodule // testbench
